// [rtl/mpio_pkg.sv]
/*
 * constants shared by the port block: register offsets, field positions,
 * reset values and external bus phase lengths.
 * assumes a 32-bit AHB-Lite slave decoding the low address byte.
 */
package mpio_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_P1_OUT   = 8'h00;
    localparam logic [7:0] OFS_P1_DIR   = 8'h04;
    localparam logic [7:0] OFS_P1_MODE  = 8'h08;
    localparam logic [7:0] OFS_P1_IN    = 8'h0c;
    localparam logic [7:0] OFS_P3_MODE  = 8'h10;
    localparam logic [7:0] OFS_PORT_CONFIGURATION_REG     = 8'h14;
    localparam logic [7:0] OFS_P3_OUT   = 8'h18;
    localparam logic [7:0] OFS_P3_IN    = 8'h1c;
    localparam logic [7:0] OFS_IRQ      = 8'h20;
    localparam logic [7:0] OFS_XB_ADDR  = 8'h24;
    localparam logic [7:0] OFS_XB_WDATA = 8'h28;
    localparam logic [7:0] OFS_XB_CTRL  = 8'h2c;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int P1M_OD_BIT     = 2;
    localparam int P1M_REL_BIT    = 3;
    localparam int P3M_ANALOG_BIT = 1;
    localparam int P3M_P2HS_BIT   = 3;
    localparam int P3M_P0HS_BIT   = 4;
    localparam int P3M_TIMER_OUTPUT_LINE_BIT   = 5;
    localparam int PORT_CONFIGURATION_REG_CMPO_BIT  = 0;
    localparam int IRQ_SEL_LSB    = 6;
    localparam int XBC_READ_BIT   = 0;
    localparam int XBC_WIDE_BIT   = 1;

    // ------------------------------------------------------------------
    // first port modes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] P1_MODE_IO  = 2'h0;
    localparam logic [1:0] P1_MODE_BUS = 2'h1;
    localparam logic [1:0] P1_MODE_HS  = 2'h2;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [3:0] RST_NIBBLE  = 4'h0;

    // ------------------------------------------------------------------
    // external bus phase lengths in hclk cycles
    // ------------------------------------------------------------------
    localparam logic [3:0] XB_AS_CYC   = 4'h3;
    localparam logic [3:0] XB_DS_CYC   = 4'h6;
    localparam logic [3:0] XB_HOLD_CYC = 4'h2;

    typedef enum logic [1:0] {
        XB_IDLE,
        XB_ADDR,
        XB_DATA,
        XB_HOLD
    } mpio_xb_state_t;

endpackage

// [rtl/mpio_sync.sv]
/*
 * three-stage synchroniser for pin inputs with agreement filter.
 * assumes inputs are asynchronous to hclk.
 */
`timescale 1ns/1ps
module mpio_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // pins in, filtered level out
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_o <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_o[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

// [rtl/mpio_edge.sv]
/*
 * per-line edge detector with separate rise and fall enables.
 * assumes inputs are already synchronous to hclk.
 */
`timescale 1ns/1ps
module mpio_edge #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // levels and edge selection
    input  wire logic [W-1:0] sig_i,
    input  wire logic [W-1:0] rise_en_i,
    input  wire logic [W-1:0] fall_en_i,
    // one-cycle event pulses
    output logic      [W-1:0] evt_o
);

    logic [W-1:0] prev_q;
    logic         arm_q;

    // first sampled cycle only primes the history, no false edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= '0;
            arm_q  <= 1'b0;
        end else begin
            prev_q <= sig_i;
            arm_q  <= 1'b1;
        end
    end

    always_comb begin
        evt_o = {W{arm_q}} & ((rise_en_i & sig_i & ~prev_q)
                            | (fall_en_i & ~sig_i & prev_q));
    end

endmodule

// [rtl/mpio_port13.sv]
/*
 * first and third-type port logic: bidirectional byte port with io,
 * multiplexed external bus and handshake modes, plus the mixed
 * input/output port with comparators, edge interrupts and timer pins.
 * assumes an AHB-Lite master on hclk and pin pads resolving o/oe.
 */
// Function
// - first port: eight lines, input, output or multiplexed address/data
// - one global push-pull or open-drain select for first port outputs
// - handshake uses two second-port lines as ready and data-available
// - external access needs bus mode; upper address goes on port zero
// - release first port, port zero and strobes to high impedance
// - second port: low four lines inputs, high four push-pull outputs
// - analog mode bit enables two comparators against line three
// - configuration bit D0 drives comparator results on lines four, seven
// - lines zero, three falling; lines one, two selectable edge interrupts
// - timer input from input line one, timer output on line six
// - zeroth, first, second port handshake lines on second port
// - request register D7, D6 select edges for lines one and two
// - comparator one to request two, comparator two to request zero
`timescale 1ns/1ps
module mpio_port13
    import mpio_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // first port pins
    input  wire logic [7:0]  p1_i,
    output logic      [7:0]  p1_o,
    output logic      [7:0]  p1_oe,
    // port zero upper address pins
    output logic      [7:0]  p0_o,
    output logic      [7:0]  p0_oe,
    // external bus strobes, active low
    output logic             addr_strobe_line_n_o,
    output logic             addr_strobe_line_n_oe,
    output logic             data_strobe_line_n_o,
    output logic             data_strobe_line_n_oe,
    output logic             rd_wr_n_o,
    output logic             rd_wr_n_oe,
    // second port pins: inputs are lines 3..0, outputs lines 7..4
    input  wire logic [3:0]  p3_i,
    output logic      [3:0]  p3_o,
    // comparator front-end decisions
    input  wire logic        comparator_one_i,
    input  wire logic        comparator_two_i,
    // counter/timer and other ports' handshake alternate functions
    output logic             timer_input_line,
    input  wire logic        timer_output_line,
    input  wire logic        p0_hs_out_i,
    output logic             p0_hs_in_o,
    input  wire logic        p2_hs_out_i,
    output logic             p2_hs_in_o,
    // interrupt requests towards the core
    output logic      [3:0]  irq_req_o
);

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    logic       accept;
    logic       wr_q;
    logic       rd_wait_q;
    logic [7:0] addr_q;
    logic [7:0] wd;
    logic [31:0] rd_mux;
    logic [31:0] hrdata_q;

    assign accept    = hsel & htrans[1] & hready;
    assign hreadyout = ~rd_wait_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign wd        = hwdata[7:0];

    // reads take one wait state so that a write just before is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q      <= 1'b0;
            rd_wait_q <= 1'b0;
            addr_q    <= RST_BYTE;
        end else begin
            wr_q      <= accept & hwrite;
            rd_wait_q <= accept & ~hwrite;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_q && (addr_q == ofs);
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [13:0] syn;
    logic [7:0]  p1s;
    logic [3:0]  p3s;
    logic        cmp1s;
    logic        cmp2s;

    mpio_sync #(.W(14)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_i   ({comparator_two_i, comparator_one_i, p3_i, p1_i}),
        .level_o (syn)
    );

    assign p1s   = syn[7:0];
    assign p3s   = syn[11:8];
    assign cmp1s = syn[12];
    assign cmp2s = syn[13];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0] p1_out_q;
    logic [7:0] p1_dir_q;
    logic [3:0] p1_mode_q;
    logic [7:0] second_port_mode_reg_q;
    logic [7:0] port_configuration_reg_q;
    logic [7:0] p3_out_q;
    logic [1:0] edge_sel_q;
    logic [15:0] xb_addr_q;
    logic [7:0] xb_wdata_q;

    // new settings act from the clock after the write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p1_out_q                 <= RST_BYTE;
            p1_dir_q                 <= RST_BYTE;
            p1_mode_q                <= RST_NIBBLE;
            second_port_mode_reg_q   <= RST_BYTE;
            port_configuration_reg_q <= RST_BYTE;
            p3_out_q                 <= RST_BYTE;
            edge_sel_q               <= 2'h0;
            xb_addr_q                <= 16'h0000;
            xb_wdata_q               <= RST_BYTE;
        end else begin
            if (wr_hit(OFS_P1_OUT))   p1_out_q   <= wd;
            if (wr_hit(OFS_P1_DIR))   p1_dir_q   <= wd;
            if (wr_hit(OFS_P1_MODE))  p1_mode_q  <= wd[3:0];
            if (wr_hit(OFS_P3_MODE))  second_port_mode_reg_q <= wd;
            if (wr_hit(OFS_PORT_CONFIGURATION_REG))     port_configuration_reg_q <= wd;
            if (wr_hit(OFS_P3_OUT))   p3_out_q   <= wd;
            if (wr_hit(OFS_IRQ))      edge_sel_q <= wd[7:6];
            if (wr_hit(OFS_XB_ADDR))  xb_addr_q  <= hwdata[15:0];
            if (wr_hit(OFS_XB_WDATA)) xb_wdata_q <= wd;
        end
    end

    logic [1:0] p1_mode;
    logic       open_drain;
    logic       release_bus;
    logic       analog;
    logic       cmp_out_en;

    assign p1_mode     = p1_mode_q[1:0];
    assign open_drain  = p1_mode_q[P1M_OD_BIT];
    assign release_bus = p1_mode_q[P1M_REL_BIT];
    assign analog      = second_port_mode_reg_q[P3M_ANALOG_BIT];
    assign cmp_out_en  = port_configuration_reg_q[PORT_CONFIGURATION_REG_CMPO_BIT];

    // ------------------------------------------------------------------
    // interrupt request register
    // ------------------------------------------------------------------
    logic [3:0] src;
    logic [3:0] rise_en;
    logic [3:0] fall_en;
    logic [3:0] evt;
    logic [3:0] irq_q;
    logic       cmp_one;
    logic       cmp_two;

    // comparators only report while analog mode is on
    assign cmp_one = analog & cmp1s;
    assign cmp_two = analog & cmp2s;

    // request 0 from line two or comparator two, 2 from line one or
    // comparator one
    assign src = {p3s[0],
                  analog ? cmp1s : p3s[1],
                  p3s[3],
                  analog ? cmp2s : p3s[2]};

    // lines zero and three fall only; one and two per select
    assign fall_en = {1'b1, ~(edge_sel_q == 2'h2), 1'b1,
                      ~(edge_sel_q == 2'h1)};
    assign rise_en = {1'b0, edge_sel_q[1], 1'b0, edge_sel_q[0]};

    mpio_edge #(.W(4)) u_edge (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .sig_i     (src),
        .rise_en_i (rise_en),
        .fall_en_i (fall_en),
        .evt_o     (evt)
    );

    // a new edge wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= RST_NIBBLE;
        end else if (wr_hit(OFS_IRQ)) begin
            irq_q <= wd[3:0] | evt;
        end else begin
            irq_q <= irq_q | evt;
        end
    end

    assign irq_req_o = irq_q;

    // ------------------------------------------------------------------
    // first port handshake
    // ------------------------------------------------------------------
    logic       hs_mode;
    logic       hs_out_dir;
    logic       hs_dav_n_q;
    logic       hs_rdy_q;
    logic [7:0] hs_data_q;

    assign hs_mode    = (p1_mode == P1_MODE_HS);
    assign hs_out_dir = p1_dir_q[0];

    // output: write raises data-available, partner's ready fall ends it;
    // input: partner's data-available fall latches, a read re-arms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_dav_n_q <= 1'b1;
            hs_rdy_q   <= 1'b1;
            hs_data_q  <= RST_BYTE;
        end else if (!hs_mode) begin
            hs_dav_n_q <= 1'b1;
            hs_rdy_q   <= 1'b1;
        end else if (hs_out_dir) begin
            if (wr_hit(OFS_P1_OUT)) begin
                hs_dav_n_q <= 1'b0;
            end else if (evt[1]) begin
                hs_dav_n_q <= 1'b1;
            end
        end else begin
            if (evt[1] && hs_rdy_q) begin
                hs_data_q <= p1s;
                hs_rdy_q  <= 1'b0;
            end else if (rd_wait_q && addr_q == OFS_P1_IN) begin
                hs_rdy_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // external memory cycle
    // ------------------------------------------------------------------
    mpio_xb_state_t xb_state_q;
    logic [3:0]     xb_cnt_q;
    logic           xb_rd_q;
    logic           xb_wide_q;
    logic [7:0]     xb_rdata_q;
    logic           xb_start;

    // only honoured in bus mode and while idle
    assign xb_start = wr_hit(OFS_XB_CTRL) && xb_state_q == XB_IDLE
                      && p1_mode == P1_MODE_BUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xb_state_q <= XB_IDLE;
            xb_cnt_q   <= 4'h0;
            xb_rd_q    <= 1'b0;
            xb_wide_q  <= 1'b0;
            xb_rdata_q <= RST_BYTE;
        end else begin
            xb_cnt_q <= xb_cnt_q - 4'h1;
            unique case (xb_state_q)
                XB_IDLE: begin
                    if (xb_start) begin
                        xb_state_q <= XB_ADDR;
                        xb_cnt_q   <= XB_AS_CYC - 4'h1;
                        xb_rd_q    <= wd[XBC_READ_BIT];
                        xb_wide_q  <= wd[XBC_WIDE_BIT];
                    end
                end
                XB_ADDR: begin
                    if (xb_cnt_q == 4'h0) begin
                        xb_state_q <= XB_DATA;
                        xb_cnt_q   <= XB_DS_CYC - 4'h1;
                    end
                end
                XB_DATA: begin
                    // strobe long enough to cover pin sync latency
                    if (xb_cnt_q == 4'h0) begin
                        xb_state_q <= XB_HOLD;
                        xb_cnt_q   <= XB_HOLD_CYC - 4'h1;
                        if (xb_rd_q) begin
                            xb_rdata_q <= p1s;
                        end
                    end
                end
                XB_HOLD: begin
                    if (xb_cnt_q == 4'h0) begin
                        xb_state_q <= XB_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin drive, registered
    // ------------------------------------------------------------------
    logic [7:0] p1_val;
    logic [7:0] p1_en;
    logic       xb_busy;
    logic [3:0] p3_d;

    assign xb_busy = (xb_state_q != XB_IDLE);

    always_comb begin
        p1_val = p1_out_q;
        p1_en  = p1_dir_q;
        if (hs_mode) begin
            p1_en = {8{hs_out_dir}};
        end else if (p1_mode == P1_MODE_BUS) begin
            p1_val = (xb_state_q == XB_ADDR) ? xb_addr_q[7:0] : xb_wdata_q;
            p1_en  = {8{xb_state_q == XB_ADDR
                        || (xb_busy && !xb_rd_q)}};
        end
    end

    // line four: comparator, then handshake, then plain output
    always_comb begin
        p3_d[0] = cmp_out_en ? cmp_one
                : hs_mode ? (hs_out_dir ? hs_dav_n_q : hs_rdy_q)
                : p3_out_q[4];
        p3_d[1] = second_port_mode_reg_q[P3M_P0HS_BIT] ? p0_hs_out_i
                : p3_out_q[5];
        p3_d[2] = second_port_mode_reg_q[P3M_TIMER_OUTPUT_LINE_BIT] ? timer_output_line
                : second_port_mode_reg_q[P3M_P2HS_BIT] ? p2_hs_out_i
                : p3_out_q[6];
        p3_d[3] = cmp_out_en ? cmp_two : p3_out_q[7];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p1_o                  <= RST_BYTE;
            p1_oe                 <= RST_BYTE;
            p0_o                  <= RST_BYTE;
            p0_oe                 <= RST_BYTE;
            addr_strobe_line_n_o  <= 1'b1;
            addr_strobe_line_n_oe <= 1'b0;
            data_strobe_line_n_o  <= 1'b1;
            data_strobe_line_n_oe <= 1'b0;
            rd_wr_n_o             <= 1'b1;
            rd_wr_n_oe            <= 1'b0;
            p3_o                  <= RST_NIBBLE;
        end else begin
            p1_o <= p1_val;
            // open drain drives only the low level
            p1_oe <= release_bus ? RST_BYTE
                   : p1_en & (~{8{open_drain}} | ~p1_val);
            p0_o  <= xb_addr_q[15:8];
            p0_oe <= {8{xb_busy && xb_wide_q && !release_bus}};
            addr_strobe_line_n_o  <= ~(xb_state_q == XB_ADDR);
            data_strobe_line_n_o  <= ~(xb_state_q == XB_DATA);
            rd_wr_n_o             <= ~xb_busy | xb_rd_q;
            addr_strobe_line_n_oe <= ~release_bus;
            data_strobe_line_n_oe <= ~release_bus;
            rd_wr_n_oe            <= ~release_bus;
            p3_o <= p3_d;
        end
    end

    // alternate inputs straight from synchronised lines
    assign timer_input_line = p3s[1];
    assign p2_hs_in_o       = p3s[1];
    assign p0_hs_in_o       = p3s[2];

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_q)
            OFS_P1_OUT:   rd_mux[7:0] = p1_out_q;
            OFS_P1_DIR:   rd_mux[7:0] = p1_dir_q;
            OFS_P1_MODE:  rd_mux[3:0] = p1_mode_q;
            OFS_P1_IN:    rd_mux[7:0] = (hs_mode && !hs_out_dir)
                                        ? hs_data_q : p1s;
            OFS_P3_MODE:  rd_mux[7:0] = second_port_mode_reg_q;
            OFS_PORT_CONFIGURATION_REG:     rd_mux[7:0] = port_configuration_reg_q;
            OFS_P3_OUT:   rd_mux[7:0] = p3_out_q;
            OFS_P3_IN:    rd_mux[7:0] = {hs_rdy_q, hs_dav_n_q,
                                         cmp_two, cmp_one, p3s};
            OFS_IRQ:      rd_mux[7:0] = {edge_sel_q, 2'h0, irq_q};
            OFS_XB_ADDR:  rd_mux[15:0] = xb_addr_q;
            OFS_XB_WDATA: rd_mux[7:0] = xb_wdata_q;
            OFS_XB_CTRL:  rd_mux[15:0] = {xb_rdata_q, 5'h00,
                                          xb_wide_q, xb_rd_q, xb_busy};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_wait_q) begin
            hrdata_q <= rd_mux;
        end
    end

endmodule

// [tb/mpio_checker.sv]
/* pin timing checks for the port block.
   assumes a bind into mpio_port13. */
`timescale 1ns/1ps
module mpio_checker (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // pins
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p0_oe,
    input wire logic       addr_strobe_line_n_o,
    input wire logic       addr_strobe_line_n_oe,
    input wire logic       data_strobe_line_n_o,
    input wire logic       data_strobe_line_n_oe,
    input wire logic       rd_wr_n_o,
    input wire logic [3:0] p3_i,
    input wire logic       timer_input_line,
    input wire logic       p0_hs_in_o
);
    wire logic a_n = addr_strobe_line_n_o;
    wire logic d_n = data_strobe_line_n_o;
    wire logic [16:0] drv = {p1_oe, p0_oe, data_strobe_line_n_oe};
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rel; !addr_strobe_line_n_oe |-> drv == 17'h0; endproperty
    property p_asl; $fell(a_n) |=> !a_n ##1 !a_n ##1 a_n; endproperty
    property p_dsl; $fell(d_n) |=> (!d_n) [*5] ##1 d_n; endproperty
    property p_ads; $rose(a_n) |-> !d_n; endproperty
    property p_adr; !a_n |-> p1_oe == 8'hff; endproperty
    property p_rdz; !d_n && rd_wr_n_o |-> p1_oe == 8'h00; endproperty
    // eight samples cover the sync flops
    property p_tin; p3_i[1] [*8] |-> timer_input_line; endproperty
    property p_hs; (!p3_i[2]) [*8] |-> !p0_hs_in_o; endproperty
    a_rel: assert property (p_rel) else $error("release");
    a_asl: assert property (p_asl) else $error("as width");
    a_dsl: assert property (p_dsl) else $error("ds width");
    a_ads: assert property (p_ads) else $error("as to ds");
    a_adr: assert property (p_adr) else $error("address");
    a_rdz: assert property (p_rdz) else $error("read drive");
    a_tin: assert property (p_tin) else $error("timer in");
    a_hs: assert property (p_hs) else $error("handshake in");
    c_rd: cover property (!d_n && rd_wr_n_o);
    c_wr: cover property (!d_n && !rd_wr_n_o);
    c_rel: cover property (!addr_strobe_line_n_oe);
endmodule
bind mpio_port13 mpio_checker chk_u (.hclk, .hresetn, .p1_oe, .p0_oe,
    .addr_strobe_line_n_o, .addr_strobe_line_n_oe, .data_strobe_line_n_o,
    .data_strobe_line_n_oe, .rd_wr_n_o, .p3_i, .timer_input_line,
    .p0_hs_in_o);

// [tb/mpio_pins_model.sv]
/* memory or peripheral on the first port pins.
   assumes the o/oe pins of the port block. */
`timescale 1ns/1ps
module mpio_pins_model (
    // block pins
    input  wire logic [7:0] p1_o,
    input  wire logic [7:0] p1_oe,
    input  wire logic       ds_n,
    input  wire logic       rd,
    // bench control
    input  wire logic       peer_en,
    input  wire logic [7:0] peer_byte,
    // resolved level
    output logic      [7:0] p1_i
);
    logic [7:0] ext;
    // inverted image when nobody drives, so stale data never passes
    assign ext = (peer_en || (!ds_n && rd)) ? peer_byte : ~p1_o;
    assign p1_i = (p1_oe & p1_o) | (~p1_oe & ext);
endmodule

// [tb/mpio_port13_bench.sv]
/* bench for the port block: register bus, pins, routing.
   assumes the pin model and the bound checker. */
`timescale 1ns/1ps
module mpio_port13_bench import mpio_pkg::*;
;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1;
    logic hwrite = 1'h0, peer_en = 1'h0, timer_output_line = 1'h0;
    logic comparator_one_i = 1'h0, comparator_two_i = 1'h0, hresp;
    logic p0_hs_out_i = 1'h0, p2_hs_out_i = 1'h0, hreadyout, rd_wr_n_o;
    logic timer_input_line, p0_hs_in_o, p2_hs_in_o, rd_wr_n_oe;
    logic addr_strobe_line_n_o, addr_strobe_line_n_oe;
    logic data_strobe_line_n_o, data_strobe_line_n_oe;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] p3_i = 4'hf, p3_o, irq_req_o;
    logic [7:0] p1_i, p1_o, p1_oe, p0_o, p0_oe;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    int miscompares = 0, checks = 0;
    always #5 hclk = ~hclk;
    mpio_port13 dut_u (.*, .hready(hreadyout));
    mpio_pins_model pins_u (.p1_o, .p1_oe, .ds_n(data_strobe_line_n_o),
        .rd(rd_wr_n_o), .peer_en, .peer_byte(8'h3c), .p1_i);
    // ------
    // tasks
    // ------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n = 0;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 9);
        if (hreadyout !== 1'h1) begin
            miscompares++;
            finish_test;
        end
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'h1, a, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'h0, a, 32'h0, x);
        chk(x, e);
    endtask
    // ---------
    // scenarios
    // ---------
    task automatic t_io;
        rdc(OFS_P1_DIR, 32'h0);
        rdc(8'h30, 32'h0);
        wr(OFS_P1_DIR, 32'hff);
        wr(OFS_P1_OUT, 32'ha5);
        cyc(2);
        chk({p1_oe, p1_o}, 32'hffa5);
        wr(OFS_P1_MODE, 32'h4);
        cyc(2);
        chk(p1_oe, 32'h5a);
        wr(OFS_P1_DIR, 32'h0);
        peer_en <= 1'h1;
        cyc(8);
        rdc(OFS_P1_IN, 32'h3c);
        peer_en <= 1'h0;
    endtask
    task automatic t_xb;
        int n;
        wr(OFS_P1_MODE, {30'h0, P1_MODE_BUS});
        wr(OFS_XB_ADDR, 32'h1234);
        wr(OFS_XB_WDATA, 32'h77);
        wr(OFS_XB_CTRL, 32'h2);
        for (n = 0; n < 30 && data_strobe_line_n_o; n++) @(posedge hclk);
        chk({rd_wr_n_o, p0_o, p1_o}, 32'h1277);
        cyc(12);
        wr(OFS_XB_CTRL, 32'h1);
        for (n = 0; n < 30 && addr_strobe_line_n_o; n++) @(posedge hclk);
        chk({p0_oe, p1_o}, 32'h34);
        cyc(12);
        rdc(OFS_XB_CTRL, 32'h3c02);
        wr(OFS_P1_MODE, 32'h8);
        cyc(2);
        chk({addr_strobe_line_n_oe, rd_wr_n_oe, p1_oe}, 32'h0);
        wr(OFS_P1_MODE, 32'h2);
    endtask
    task automatic t_cmp;
        wr(OFS_P3_MODE, 32'h2);
        wr(OFS_PORT_CONFIGURATION_REG, 32'h1);
        cyc(12);
        wr(OFS_IRQ, 32'hc0);
        comparator_one_i <= 1'h1;
        cyc(12);
        chk({p3_o[3], p3_o[0]}, 32'h1);
        rdc(OFS_IRQ, 32'hc4);
        wr(OFS_P3_MODE, 32'h0);
        wr(OFS_PORT_CONFIGURATION_REG, 32'h0);
    endtask
    task automatic t_irq;
        logic [1:0] s;
        p3_i <= 4'h9;
        cyc(12);
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            wr(OFS_IRQ, {24'h0, s, 6'h0});
            p3_i <= 4'hf;
            cyc(12);
            rdc(OFS_IRQ, {24'h0, s, 3'h0, s[1], 1'h0, s[0]});
            wr(OFS_IRQ, {24'h0, s, 6'h0});
            p3_i <= 4'h9;
            cyc(12);
            rdc(OFS_IRQ, {24'h0, s, 3'h0, s!=2'h2, 1'h0, s!=2'h1});
        end
        wr(OFS_IRQ, 32'h0);
        p3_i <= 4'h6;
        cyc(12);
        rdc(OFS_IRQ, 32'ha);
        p3_i <= 4'hf;
    endtask
    task automatic t_tmr;
        wr(OFS_P3_MODE, 32'h30);
        wr(OFS_P3_OUT, 32'h80);
        timer_output_line <= 1'h1;
        p0_hs_out_i <= 1'h1;
        cyc(3);
        chk({p2_hs_in_o, irq_req_o, p3_o}, 32'h1ae);
        rdc(OFS_P1_IN, 32'h5a);
        cyc(1);
        chk(p3_o, 32'hf);
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        t_io;
        t_xb;
        t_cmp;
        t_irq;
        t_tmr;
        finish_test;
    end
endmodule
